// ==== hw/fcid_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Flash control and identification bank
// ****************************************
module fcid_regs
	import fcid_pkg::*;
#(
	parameter logic [11:0] DEV_CODE = 12'h001,  // arbitrary neutral value
	parameter logic [3:0]  REV_CODE = 4'h0      // silicon revision
) (
	// Clock, reset, enable
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                ce,
	// Peripheral bus side (flash words)
	input  wire logic                pb_sel,
	input  wire logic                pb_wr,
	input  wire logic [FCID_AW-1:0]  pb_addr,
	input  wire logic [FCID_DW-1:0]  pb_wdata,
	output logic      [FCID_DW-1:0]  pb_rdata,
	output logic                     pb_ack,
	output logic                     pb_err,
	// Extended special register side (id words)
	input  wire logic                es_sel,
	input  wire logic                es_wr,
	input  wire logic [15:0]         es_addr,
	output logic      [FCID_DW-1:0]  es_rdata,
	output logic                     es_ack,
	output logic                     es_err,
	// Flash word views for the controller
	output logic      [FCID_DW-1:0]  ctl0_lo
);
	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic [4:0] dec_flash(input logic [FCID_AW-1:0] a);
		unique case (a)
			FCID_A_CTL0_LO: dec_flash = 5'h10;
			FCID_A_CTL0_HI: dec_flash = 5'h11;
			FCID_A_CTL1_LO: dec_flash = 5'h12;
			FCID_A_CTL1_HI: dec_flash = 5'h13;
			FCID_A_DAT0_LO: dec_flash = 5'h14;
			FCID_A_DAT0_HI: dec_flash = 5'h15;
			FCID_A_DAT1_LO: dec_flash = 5'h16;
			FCID_A_DAT1_HI: dec_flash = 5'h17;
			FCID_A_ADR_LO:  dec_flash = 5'h18;
			FCID_A_ADR_HI:  dec_flash = 5'h19;
			FCID_A_ERR:     dec_flash = 5'h1a;
			FCID_A_WPI_LO:  dec_flash = 5'h1b;
			FCID_A_WPI_HI:  dec_flash = 5'h1c;
			FCID_A_APR0:    dec_flash = 5'h1d;
			FCID_A_APR1_LO: dec_flash = 5'h1e;
			FCID_A_APR1_HI: dec_flash = 5'h1f;
			default:        dec_flash = 5'h00;  // bit 4 low: unmapped
		endcase
	endfunction : dec_flash

	function automatic logic es_hit(input logic [15:0] a);
		es_hit = (a[15:3] == FCID_A_ID_PROG[15:3]) && !a[0];
	endfunction : es_hit

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		fcid_state_e      pb_st;     // flash access phase
		logic             pb_bad;    // unmapped flash access
		fcid_state_e      es_st;     // id access phase
		logic             es_bad;    // unmapped or write to id
		logic [15:0]      es_q;      // id read word
		logic [15:0]      ctl0;      // mirror of control word 0
	} fcid_s;

	fcid_s st;       // current state
	fcid_s next_st;  // next state

	logic [4:0]         hit;     // flash decode
	logic [15:0]        rf_q;    // regfile read word
	logic [15:0]        id_w;    // id rom word
	logic               wr_go;   // regfile write strobe

	assign hit   = dec_flash(pb_addr);
	assign wr_go = pb_sel && pb_wr && hit[4] && st.pb_st == FCID_IDLE;

	// ****************************************
	// Submodules
	// ****************************************
	fcid_regfile u_rf (
		.clk     (clk),
		.rst     (rst),
		.ce      (ce),
		.wr_en   (wr_go),
		.wr_idx  (hit[3:0]),
		.wr_data (pb_wdata),
		.rd_idx  (hit[3:0]),
		.rd_data (rf_q)
	);

	fcid_idrom #(
		.DEV_CODE (DEV_CODE),
		.REV_CODE (REV_CODE)
	) u_id (
		.sel  (es_addr[2:1]),
		.word (id_w)
	);

	// ****************************************
	// Access sequencing
	// ****************************************
	// One-cycle answer after each strobe, one idle cycle between
	always_comb begin
		next_st = st;
		unique case (st.pb_st)
			FCID_IDLE: if (pb_sel) begin
				next_st.pb_st  = FCID_DONE;
				next_st.pb_bad = !hit[4];
				if (wr_go && hit[3:0] == 4'h0)
					next_st.ctl0 = pb_wdata;
			end
			FCID_DONE: next_st.pb_st = FCID_IDLE;
			default:   next_st.pb_st = FCID_IDLE;
		endcase
		unique case (st.es_st)
			FCID_IDLE: if (es_sel) begin
				next_st.es_st  = FCID_DONE;
				next_st.es_bad = !es_hit(es_addr) || es_wr;  // writes dropped
				next_st.es_q   = es_hit(es_addr) ? id_w : 16'h0000;
			end
			FCID_DONE: next_st.es_st = FCID_IDLE;
			default:   next_st.es_st = FCID_IDLE;
		endcase
	end

	// Registered state
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '{FCID_IDLE, 1'b0, FCID_IDLE, 1'b0, 16'h0000, FCID_RST_ZERO};
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Outputs
	assign pb_ack   = st.pb_st == FCID_DONE;
	assign pb_err   = pb_ack && st.pb_bad;
	assign pb_rdata = (pb_ack && !st.pb_bad) ? rf_q : 16'h0000;
	assign es_ack   = st.es_st == FCID_DONE;
	assign es_err   = es_ack && st.es_bad;
	assign es_rdata = es_ack ? st.es_q : 16'h0000;
	assign ctl0_lo  = st.ctl0;

	// ****************************************
	// Checks
	// ****************************************
	// First edge out of reset: no answer pending, control copy cleared
	property p_flash_rst_val;
		@(posedge clk) disable iff (rst)
		$fell(rst) |-> (ctl0_lo == FCID_RST_ZERO && !pb_ack && !es_ack);
	endproperty
	a_flash_rst_val: assert property (p_flash_rst_val) else $error("reset lost");
	property p_ack_one;
		@(posedge clk) disable iff (rst)
		(ce && pb_sel && st.pb_st == FCID_IDLE) |=> pb_ack;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("flash access not answered");
	property p_wr_back;
		@(posedge clk) disable iff (rst)
		(ce && wr_go && hit == 5'h10) |=> (ctl0_lo == $past(pb_wdata));
	endproperty
	a_wr_back: assert property (p_wr_back) else $error("control word not stored");
	property p_mem_word;
		@(posedge clk) disable iff (rst)
		(ce && es_sel && st.es_st == FCID_IDLE && es_addr == FCID_A_ID_MEM)
			|=> es_rdata == FCID_RST_MEM;
	endproperty
	a_mem_word: assert property (p_mem_word) else $error("memory id wrong");
	property p_prog_word;
		@(posedge clk) disable iff (rst)
		(ce && es_sel && st.es_st == FCID_IDLE && es_addr == FCID_A_ID_PROG)
			|=> es_rdata == FCID_RST_PROG;
	endproperty
	a_prog_word: assert property (p_prog_word) else $error("voltage id wrong");
	property p_id_wr_err;
		@(posedge clk) disable iff (rst)
		(ce && es_sel && es_wr && st.es_st == FCID_IDLE) |=> es_err;
	endproperty
	a_id_wr_err: assert property (p_id_wr_err) else $error("id write not refused");
	property p_bad_addr;
		@(posedge clk) disable iff (rst)
		(ce && pb_sel && !hit[4] && st.pb_st == FCID_IDLE) |=> (pb_err && pb_rdata == 16'h0000);
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("unmapped flash access");
	// Id words answer in one cycle, no extra wait states
	property p_es_ack_one;
		@(posedge clk) disable iff (rst)
		(ce && es_sel && st.es_st == FCID_IDLE) |=> es_ack;
	endproperty
	a_es_ack_one: assert property (p_es_ack_one) else $error("id not answered");
endmodule : fcid_regs
`default_nettype wire

// ==== hw/fcid_pkg.sv ====
// Function
// - Sixteen flash words decoded at fixed addresses
// - Whole-word access only, no bit operations
// - Data and protection halves reset ones, control, address and error reset zero
// - Access protect0 resets to fixed pattern
// - Four identification words, two bytes apart
// - Identification words ignore all writes
// - Chip word: device code, revision low
// - Memory size field times four gives kilobytes
// - Memory kind reports standard flash
// - Voltage code twenty times code over 256
// - Upper voltage byte zero, no external supply
package fcid_pkg;
	// ****************************************
	// Widths and register count
	// ****************************************
	localparam int FCID_AW    = 24;            // physical address width
	localparam int FCID_DW    = 16;            // register word width
	localparam int FCID_NREG  = 16;            // flash register count
	localparam int FCID_IXW   = 4;             // flash register index width

	// ****************************************
	// Flash register byte addresses
	// ****************************************
	localparam logic [23:0] FCID_A_CTL0_LO = 24'h0e0000;
	localparam logic [23:0] FCID_A_CTL0_HI = 24'h0e0002;
	localparam logic [23:0] FCID_A_CTL1_LO = 24'h0e0004;
	localparam logic [23:0] FCID_A_CTL1_HI = 24'h0e0006;
	localparam logic [23:0] FCID_A_DAT0_LO = 24'h0e0008;
	localparam logic [23:0] FCID_A_DAT0_HI = 24'h0e000a;
	localparam logic [23:0] FCID_A_DAT1_LO = 24'h0e000c;
	localparam logic [23:0] FCID_A_DAT1_HI = 24'h0e000e;
	localparam logic [23:0] FCID_A_ADR_LO  = 24'h0e0010;
	localparam logic [23:0] FCID_A_ADR_HI  = 24'h0e0012;
	localparam logic [23:0] FCID_A_ERR     = 24'h0e0014;
	localparam logic [23:0] FCID_A_WPI_LO  = 24'h0edfb4;
	localparam logic [23:0] FCID_A_WPI_HI  = 24'h0edfb6;
	localparam logic [23:0] FCID_A_APR0    = 24'h0edfb8;
	localparam logic [23:0] FCID_A_APR1_LO = 24'h0edfbc;
	localparam logic [23:0] FCID_A_APR1_HI = 24'h0edfbe;

	// ****************************************
	// Flash register reset values
	// ****************************************
	localparam logic [15:0] FCID_RST_ZERO = 16'h0000;  // address, control, error
	localparam logic [15:0] FCID_RST_ONES = 16'hffff;  // data and protection halves
	localparam logic [15:0] FCID_RST_APR0 = 16'hacff;  // access protect0 pattern

	// ****************************************
	// Identification space addresses
	// ****************************************
	localparam logic [15:0] FCID_A_ID_PROG  = 16'hf078;
	localparam logic [15:0] FCID_A_ID_MEM   = 16'hf07a;
	localparam logic [15:0] FCID_A_ID_CHIP  = 16'hf07c;
	localparam logic [15:0] FCID_A_ID_MAKER = 16'hf07e;

	// ****************************************
	// Identification fields
	// ****************************************
	localparam int          FCID_REV_LSB   = 0;        // revision_field lsb
	localparam int          FCID_DEV_LSB   = 4;        // device code lsb
	localparam int          FCID_SIZE_LSB  = 0;        // memory_size_field lsb
	localparam int          FCID_KIND_LSB  = 12;       // memory_kind_field lsb
	localparam logic [3:0]  FCID_KIND_NONE = 4'h0;     // no internal memory
	localparam logic [3:0]  FCID_KIND_MROM = 4'h1;     // mask rom
	localparam logic [3:0]  FCID_KIND_STD  = 4'h2;     // standard flash
	localparam logic [3:0]  FCID_KIND_HP   = 4'h3;     // high performance flash
	localparam logic [11:0] FCID_SIZE_512K = 12'h080;  // 512 kbytes over four
	localparam logic [7:0]  FCID_VPP_NONE  = 8'h00;    // no external supply
	localparam logic [7:0]  FCID_VDD_CODE  = 8'h40;    // programming supply code
	localparam logic [15:0] FCID_RST_MEM   = 16'h2080; // memory word value
	localparam logic [15:0] FCID_RST_PROG  = 16'h0040; // voltage word value

	// ****************************************
	// Access sequencing states
	// ****************************************
	typedef enum logic [1:0] {
		FCID_IDLE = 2'b00,  // waiting for a strobe
		FCID_DONE = 2'b01   // answer presented
	} fcid_state_e;
endpackage : fcid_pkg

// ==== hw/fcid_regfile.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Sixteen-word flash register memory
// ****************************************
module fcid_regfile
	import fcid_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// Write port
	input  wire logic                 wr_en,
	input  wire logic [FCID_IXW-1:0]  wr_idx,
	input  wire logic [FCID_DW-1:0]   wr_data,
	// Read port
	input  wire logic [FCID_IXW-1:0]  rd_idx,
	output logic      [FCID_DW-1:0]   rd_data
);
	// Storage and registered read word
	typedef struct packed {
		logic [FCID_NREG-1:0][FCID_DW-1:0] mem;
		logic [FCID_DW-1:0]                q;
	} fcid_rf_s;

	fcid_rf_s st;       // current state
	fcid_rf_s next_st;  // next state

	// Reset value by index
	function automatic logic [FCID_DW-1:0] rst_val(input int i);
		if (i >= 4 && i <= 7)
			rst_val = FCID_RST_ONES;         // data halves
		else if (i == 13)
			rst_val = FCID_RST_APR0;         // fixed pattern
		else if (i >= 11)
			rst_val = FCID_RST_ONES;         // protection halves
		else
			rst_val = FCID_RST_ZERO;         // ctl, addr, err
	endfunction : rst_val

	// Whole-word write, registered read
	always_comb begin
		next_st = st;
		if (wr_en)
			next_st.mem[wr_idx] = wr_data;   // full word only
		next_st.q = st.mem[rd_idx];
	end

	// Registered state, synchronous reset
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < FCID_NREG; i++)
				st.mem[i] <= rst_val(i);
			st.q <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign rd_data = st.q;
endmodule : fcid_regfile
`default_nettype wire

// ==== hw/fcid_idrom.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Constant identification words
// ****************************************
module fcid_idrom
	import fcid_pkg::*;
#(
	parameter logic [10:0] MAKER_CODE = 11'h001,  // arbitrary neutral value
	parameter logic [4:0]  MAKER_LOW  = 5'h01,    // arbitrary neutral value
	parameter logic [11:0] DEV_CODE   = 12'h001,  // arbitrary neutral value
	parameter logic [3:0]  REV_CODE   = 4'h0      // silicon revision
) (
	// Word select 0..3 from low address
	input  wire logic [1:0]         sel,
	output logic      [FCID_DW-1:0] word
);
	// No state here: values cannot change after reset
	always_comb begin
		unique case (sel)
			2'd0: word = {FCID_VPP_NONE, FCID_VDD_CODE};
			2'd1: word = {FCID_KIND_STD, FCID_SIZE_512K};
			2'd2: word = {DEV_CODE, REV_CODE};
			2'd3: word = {MAKER_CODE, MAKER_LOW};
		endcase
	end
endmodule : fcid_idrom
`default_nettype wire

// ==== test/fcid_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Cpu core model driving both access sides
// ****************************************
module fcid_cpu_model (
	// Clock
	input  wire logic                           clk,
	// Peripheral bus side
	output logic                                pb_sel,
	output logic                                pb_wr,
	output logic      [fcid_pkg::FCID_AW-1:0]   pb_addr,
	output logic      [fcid_pkg::FCID_DW-1:0]   pb_wdata,
	input  wire logic [fcid_pkg::FCID_DW-1:0]   pb_rdata,
	input  wire logic                           pb_ack,
	input  wire logic                           pb_err,
	// Identification side
	output logic                                es_sel,
	output logic                                es_wr,
	output logic      [15:0]                    es_addr,
	input  wire logic [fcid_pkg::FCID_DW-1:0]   es_rdata,
	input  wire logic                           es_ack,
	input  wire logic                           es_err
);
	import fcid_pkg::*;

	// Idle bus at time zero
	initial begin
		pb_sel   = 1'b0;
		es_sel   = 1'b0;
		pb_wr    = 1'b0;
		es_wr    = 1'b0;
		pb_addr  = 24'h000000;
		es_addr  = 16'h0000;
		pb_wdata = 16'h0000;
	end

	// One access; request held until the edge that samples ack
	task automatic xfer(input bit es, input bit wr, input logic [23:0] a,
		input logic [15:0] wd, output logic [15:0] rd, output logic err, output bit ok);
		int n;
		@(posedge clk);
		#1;
		es_sel   = es;
		pb_sel   = !es;
		pb_wr    = wr;
		es_wr    = wr;
		pb_addr  = a;
		es_addr  = a[15:0];
		pb_wdata = wd;  // Whole word only, no bit set or clear
		ok       = 1'b0;
		for (n = 0; n < 8 && !ok; n++) begin
			@(posedge clk);
			ok = es ? (es_ack === 1'b1) : (pb_ack === 1'b1);
		end
		rd  = es ? es_rdata : pb_rdata;
		err = es ? es_err : pb_err;
		#1;
		pb_sel   = 1'b0;
		es_sel   = 1'b0;
		// Released address and data lines must not keep their last value
		pb_addr  = ~pb_addr;
		es_addr  = ~es_addr;
		pb_wdata = ~pb_wdata;
	endtask : xfer
endmodule : fcid_cpu_model
`default_nettype wire

// ==== test/flash_ctrl_and_id_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Self-checking bench for the register bank
// ****************************************
module flash_ctrl_and_id_regs_tb;
	import fcid_pkg::*;
	localparam logic [11:0] DEV = 12'h5a3;  // Arbitrary device code
	localparam logic [3:0]  REV = 4'h7;     // Arbitrary revision
	logic        clk, rst, ce, pb_sel, pb_wr, es_sel, es_wr, pb_ack, pb_err, es_ack, es_err;
	logic [23:0] pb_addr;
	logic [15:0] pb_wdata, pb_rdata, es_addr, es_rdata, ctl0_lo, rd;
	logic        er;
	logic [15:0] nv;  // Word written while the bank is frozen
	bit          ok;
	int          errors, samples_checked, seed;
	logic [15:0] shadow [16];  // Expected flash words
	logic [23:0] bad [4] = '{24'h0e0016, 24'h0e0001, 24'h0edfba, 24'h0f0000};

	fcid_regs #(.DEV_CODE(DEV), .REV_CODE(REV)) fcid_regs_i (.clk(clk), .rst(rst),
		.ce(ce), .pb_sel(pb_sel), .pb_wr(pb_wr), .pb_addr(pb_addr), .pb_wdata(pb_wdata),
		.pb_rdata(pb_rdata), .pb_ack(pb_ack), .pb_err(pb_err), .es_sel(es_sel),
		.es_wr(es_wr), .es_addr(es_addr), .es_rdata(es_rdata), .es_ack(es_ack),
		.es_err(es_err), .ctl0_lo(ctl0_lo));
	fcid_cpu_model fcid_cpu_model_i (.clk(clk), .pb_sel(pb_sel), .pb_wr(pb_wr),
		.pb_addr(pb_addr), .pb_wdata(pb_wdata), .pb_rdata(pb_rdata), .pb_ack(pb_ack),
		.pb_err(pb_err), .es_sel(es_sel), .es_wr(es_wr), .es_addr(es_addr),
		.es_rdata(es_rdata), .es_ack(es_ack), .es_err(es_err));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************************
	// Expectation functions
	// ****************************************
	function automatic logic [23:0] faddr(int i);
		if (i < 11) return 24'h0e0000 + 24'(2 * i);
		if (i < 14) return 24'h0edfb4 + 24'(2 * (i - 11));
		return 24'h0edfbc + 24'(2 * (i - 14));
	endfunction : faddr
	function automatic logic [15:0] frst(int i);
		if (i == 13) return 16'hacff;
		return (i inside {[4:7], [11:15]}) ? 16'hffff : 16'h0000;
	endfunction : frst
	function automatic logic [15:0] idexp(int k);
		case (k)
			0:       return {8'h00, 8'h40};
			1:       return {4'h2, 12'd512 / 12'd4};
			2:       return {DEV, REV};
			default: return {11'h001, 5'h01};  // Arbitrary maker word
		endcase
	endfunction : idexp

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic report_and_stop();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	// Access with a bounded wait for ack
	task automatic acc(input bit es, input bit wr, input logic [23:0] a, input logic [15:0] wd);
		fcid_cpu_model_i.xfer(es, wr, a, wd, rd, er, ok);
		if (!ok) begin
			errors++;
			$display("CHECK FAILED ack expected 1 seen 0");
			report_and_stop();
		end
	endtask : acc
	// Reset held 16 cycles, then shadow back to reset values
	task automatic do_reset();
		rst = 1'b1;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 16; i++) shadow[i] = frst(i);
	endtask : do_reset
	task automatic read_all();
		for (int i = 15; i >= 0; i--) begin
			acc(1'b0, 1'b0, faddr(i), 16'h0000);
			check("flash word", shadow[i], rd);
		end
	endtask : read_all

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		errors          = 0;
		samples_checked = 0;
		seed            = 32'h7fd12d9f;
		ce              = 1'b1;
		rst             = 1'b1;
		do_reset();
		read_all();
		check("ctl0 copy", 16'h0000, ctl0_lo);
		// Random whole words into every flash register
		for (int i = 0; i < 16; i++) begin
			shadow[i] = 16'($random(seed));
			acc(1'b0, 1'b1, faddr(i), shadow[i]);
		end
		// Unmapped places answer with error and alias nothing
		for (int k = 0; k < 4; k++) begin
			acc(1'b0, k[0], bad[k], 16'($random(seed)));
			check("unmapped err", 16'h0001, {15'h0, er});
			check("unmapped data", 16'h0000, rd);
		end
		read_all();
		repeat (2) @(posedge clk);
		#1;
		check("ctl0 copy", shadow[0], ctl0_lo);
		// Clock enable low holds a pending write off and freezes the bank
		nv = 16'($random(seed));
		ce = 1'b0;
		fork
			acc(1'b0, 1'b1, faddr(0), nv);
			begin
				repeat (3) @(posedge clk);
				#1;
				check("frozen ctl0", shadow[0], ctl0_lo);
				check("frozen ack", 16'h0000, {15'h0, pb_ack});
				ce = 1'b1;
			end
		join
		shadow[0] = nv;
		check("ctl0 after freeze", nv, ctl0_lo);
		acc(1'b0, 1'b0, faddr(0), 16'h0000);
		check("frozen write", nv, rd);
		// Identification words, read, written, read again
		for (int k = 0; k < 8; k++) begin
			acc(1'b1, 1'b0, 24'hf078 + 24'(2 * (k % 4)), 16'h0000);
			check("id word", idexp(k % 4), rd);
			acc(1'b1, 1'b1, 24'hf078 + 24'(2 * (k % 4)), 16'($random(seed)));
			check("id write err", 16'h0001, {15'h0, er});
		end
		acc(1'b1, 1'b0, 24'h00f079, 16'h0000);
		check("id odd err", 16'h0001, {15'h0, er});
		// Second reset in mid-run restores every word
		do_reset();
		read_all();
		check("ctl0 after reset", 16'h0000, ctl0_lo);
		report_and_stop();
	end
endmodule : flash_ctrl_and_id_regs_tb
`default_nettype wire
